/* File: rtl/dac_control_and_routing.sv */
// DAC control registers, source selection, routing and zero-flag pins.
// Assumes a host on the serial control port and sources synchronous
// to REF_CLK.
`timescale 1ns/1ns
module dac_control_and_routing
  import dac_ctl_pkg::*;
(
  // Clock and reset
  input  wire logic                    REF_CLK,
  input  wire logic                    RESETN,
  // Control port
  input  wire logic                    CS_N,
  input  wire logic                    SCK,
  input  wire logic                    SDI,
  output logic                         SDO,
  // Audio sources
  input  wire stereo_s [NUM_FEEDS-1:0] SOURCE_DATA,
  input  wire logic                    VOL_ZERO_L,
  input  wire logic                    VOL_ZERO_R,
  input  wire logic                    IRQ_IN,
  // DAC and transmitter feeds
  output stereo_s                      DAC_DATA,
  output logic                         DAC_STROBE,
  output logic                         DAC_POWER_DOWN,
  output logic                         DAC_MCLK_EN,
  output stereo_s                      TX_DATA,
  // Flag pins
  output logic                         LEFT_FLAG_OR_IRQ_PIN,
  output logic                         RIGHT_FLAG_PIN
);
  typedef struct packed {
    logic [7:0] main_ctl;
    logic [7:0] clk_ctl;
    logic [7:0] zf_ctl;
    logic [7:0] pin_ctl;
    logic [7:0] sel_ctl;
    stereo_s    dac;
    logic       dac_stb;
    stereo_s    tx;
    logic       pd;
    logic       lpin;
    logic       rpin;
  } core_s;

  core_s   st_reg;
  core_s   st_next;
  reg_wr_s wr;
  logic [6:0] rd_addr;
  logic [7:0] rd_data;
  logic    fs_tick;
  logic    mclk_en;
  logic    hard;
  logic    held;
  stereo_s dac_pick;
  stereo_s tx_pick;
  stereo_s routed;
  stereo_s shaped;
  logic    zero_l;
  logic    zero_r;
  logic    flag_l;
  logic    flag_r;

  function automatic stereo_s pick(input logic [2:0] code);
    stereo_s s;
    s = '0;
    case (code)
      SEL_ADC:      s = SOURCE_DATA[0];
      SEL_RX:       s = SOURCE_DATA[1];
      SEL_PLAY:     s = SOURCE_DATA[2];
      SEL_AUX:      s = SOURCE_DATA[3];
      SEL_RATECONV: s = SOURCE_DATA[4];
      default:      s = '0;
    endcase
    return s;
  endfunction

  function automatic logic pin_level(input logic active, input logic high);
    return high ? active : !active;
  endfunction

  dac_spi_port u_spi (
    .clk     (REF_CLK),
    .rst_n   (RESETN),
    .cs_n    (CS_N),
    .sck     (SCK),
    .sdi     (SDI),
    .sdo     (SDO),
    .rd_data (rd_data),
    .rd_addr (rd_addr),
    .wr      (wr)
  );

  // Digital reset stops the sample clock too, so the path restarts aligned
  dac_rate_gen u_rate (
    .clk        (REF_CLK),
    .rst_n      (RESETN),
    .clr        (held),
    .div_sel    (st_reg.clk_ctl[DIV_LSB+1:DIV_LSB]),
    .interp_sel (st_reg.clk_ctl[INTERP_LSB+1:INTERP_LSB]),
    .mclk_en    (mclk_en),
    .fs_tick    (fs_tick)
  );

  always_comb begin
    case (rd_addr)
      ADDR_SOURCE_SEL: rd_data = st_reg.sel_ctl;
      ADDR_MAIN:       rd_data = st_reg.main_ctl;
      ADDR_CLK_FILT:   rd_data = st_reg.clk_ctl;
      ADDR_ZERO_FLAG:  rd_data = st_reg.zf_ctl;
      ADDR_PIN_FUNC:   rd_data = st_reg.pin_ctl;
      default:         rd_data = 8'h00;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    st_next.dac_stb = 1'b0;
    // Reserved bits are masked off so they always read back zero
    if (wr.stb) begin
      case (wr.addr)
        ADDR_SOURCE_SEL: st_next.sel_ctl = wr.data & SEL_MASK;
        ADDR_MAIN:       st_next.main_ctl = wr.data & MAIN_MASK;
        ADDR_CLK_FILT:   st_next.clk_ctl = wr.data & CLK_MASK;
        ADDR_ZERO_FLAG:  st_next.zf_ctl = wr.data & ZF_MASK;
        ADDR_PIN_FUNC:   st_next.pin_ctl = wr.data & PIN_MASK;
        default:         ;
      endcase
    end

    hard = st_reg.main_ctl[HARD_BIT];
    held = hard || st_reg.main_ctl[DIG_BIT];
    dac_pick = pick(st_reg.sel_ctl[DACSEL_LSB+2:DACSEL_LSB]);
    tx_pick = pick(st_reg.sel_ctl[TXSEL_LSB+2:TXSEL_LSB]);

    case (st_reg.main_ctl[ROUTE_LSB+1:ROUTE_LSB])
      ROUTE_NORMAL: routed = dac_pick;
      ROUTE_BOTH_R: routed = '{dac_pick.right, dac_pick.right};
      ROUTE_BOTH_L: routed = '{dac_pick.left, dac_pick.left};
      ROUTE_SWAP:   routed = '{dac_pick.right, dac_pick.left};
      default:      routed = dac_pick;
    endcase

    // Plain two's complement negation; full-scale negative wraps
    shaped = routed;
    if (st_reg.main_ctl[INV_LSB]) begin
      shaped.left = -routed.left;
    end
    if (st_reg.main_ctl[INV_LSB+1]) begin
      shaped.right = -routed.right;
    end
    if (!st_reg.main_ctl[LSIL_BIT]) begin
      shaped.left = '0;
    end
    if (!st_reg.main_ctl[RSIL_BIT]) begin
      shaped.right = '0;
    end

    if (fs_tick) begin
      st_next.dac = shaped;
      st_next.dac_stb = 1'b1;
    end
    st_next.tx = tx_pick;
    if (held) begin
      st_next.dac = '0;
      st_next.tx = '0;
      st_next.dac_stb = 1'b0;
    end
    st_next.pd = hard;

    // Zero data is judged before mute so a muted channel is not double-counted
    zero_l = ((!st_reg.main_ctl[LSIL_BIT] || VOL_ZERO_L)
              && !st_reg.zf_ctl[SILDIS_BIT])
             || (routed.left == '0 && !st_reg.zf_ctl[NULLDIS_BIT]);
    zero_r = ((!st_reg.main_ctl[RSIL_BIT] || VOL_ZERO_R)
              && !st_reg.zf_ctl[SILDIS_BIT])
             || (routed.right == '0 && !st_reg.zf_ctl[NULLDIS_BIT]);

    flag_l = zero_l;
    flag_r = zero_r;
    if (st_reg.pin_ctl[SHARED_BIT]) begin
      case (st_reg.pin_ctl[RPIN_LSB+1:RPIN_LSB])
        RPIN_RIGHT:  flag_r = zero_r;
        RPIN_LEFT:   flag_r = zero_l;
        RPIN_EITHER: flag_r = zero_l || zero_r;
        RPIN_BOTH:   flag_r = zero_l && zero_r;
        default:     flag_r = zero_r;
      endcase
    end
    st_next.lpin = st_reg.pin_ctl[SHARED_BIT] ? IRQ_IN
                 : pin_level(flag_l, st_reg.zf_ctl[FPOL_BIT]);
    st_next.rpin = pin_level(flag_r, st_reg.zf_ctl[FPOL_BIT]);
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_reg <= '{REG_RESET, REG_RESET, REG_RESET, REG_RESET, REG_RESET,
                  '0, 1'b0, '0, 1'b0, 1'b0, 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign DAC_DATA = st_reg.dac;
  assign DAC_STROBE = st_reg.dac_stb;
  assign DAC_POWER_DOWN = st_reg.pd;
  assign DAC_MCLK_EN = mclk_en;
  assign TX_DATA = st_reg.tx;
  assign LEFT_FLAG_OR_IRQ_PIN = st_reg.lpin;
  assign RIGHT_FLAG_PIN = st_reg.rpin;

  property p_hard_quiet;
    @(posedge REF_CLK) disable iff (!RESETN)
      hard |=> (DAC_POWER_DOWN && DAC_DATA == '0 && !DAC_STROBE);
  endproperty
  a_hard_quiet: assert property (p_hard_quiet)
    else $error("hard reset left the DAC driven");

  property p_dig_regs_kept;
    @(posedge REF_CLK) disable iff (!RESETN)
      (st_reg.main_ctl[DIG_BIT] && !wr.stb) |=>
        (st_reg.clk_ctl == $past(st_reg.clk_ctl) && TX_DATA == '0);
  endproperty
  a_dig_regs_kept: assert property (p_dig_regs_kept)
    else $error("digital reset disturbed registers or left data");

  property p_tx_adc;
    @(posedge REF_CLK) disable iff (!RESETN)
      (!held && st_reg.sel_ctl[TXSEL_LSB+2:TXSEL_LSB] == SEL_ADC)
        |=> TX_DATA == $past(SOURCE_DATA[0]);
  endproperty
  a_tx_adc: assert property (p_tx_adc)
    else $error("transmitter not fed from ADC");

  property p_dac_rateconv;
    @(posedge REF_CLK) disable iff (!RESETN)
      (fs_tick && !held && st_reg.main_ctl[5:0] == 6'h03
       && st_reg.sel_ctl[DACSEL_LSB+2:DACSEL_LSB] == SEL_RATECONV)
        |=> (DAC_STROBE && DAC_DATA == $past(SOURCE_DATA[4]));
  endproperty
  a_dac_rateconv: assert property (p_dac_rateconv)
    else $error("DAC not fed from rate converter");

  property p_swap_mute;
    @(posedge REF_CLK) disable iff (!RESETN)
      (fs_tick && !held && st_reg.main_ctl[5:0] == 6'h3A)
        |=> (DAC_DATA.left == '0 && DAC_DATA.right == -$past(dac_pick.left));
  endproperty
  a_swap_mute: assert property (p_swap_mute)
    else $error("swap, invert or mute wrong");

  property p_flags_off;
    @(posedge REF_CLK) disable iff (!RESETN)
      (st_reg.zf_ctl[SILDIS_BIT] && st_reg.zf_ctl[NULLDIS_BIT]
       && !st_reg.pin_ctl[SHARED_BIT])
        |=> (LEFT_FLAG_OR_IRQ_PIN == !$past(st_reg.zf_ctl[FPOL_BIT])
             && RIGHT_FLAG_PIN == !$past(st_reg.zf_ctl[FPOL_BIT]));
  endproperty
  a_flags_off: assert property (p_flags_off)
    else $error("zero flag active with both causes disabled");

  property p_muted_flag;
    @(posedge REF_CLK) disable iff (!RESETN)
      (!st_reg.main_ctl[LSIL_BIT] && !st_reg.zf_ctl[SILDIS_BIT]
       && !st_reg.pin_ctl[SHARED_BIT])
        |=> LEFT_FLAG_OR_IRQ_PIN == $past(st_reg.zf_ctl[FPOL_BIT]);
  endproperty
  a_muted_flag: assert property (p_muted_flag)
    else $error("muted left channel did not raise its flag");

  property p_irq_pin;
    @(posedge REF_CLK) disable iff (!RESETN)
      st_reg.pin_ctl[SHARED_BIT] |=> LEFT_FLAG_OR_IRQ_PIN == $past(IRQ_IN);
  endproperty
  a_irq_pin: assert property (p_irq_pin)
    else $error("shared pin does not carry the interrupt");

  property p_right_both;
    @(posedge REF_CLK) disable iff (!RESETN)
      (st_reg.pin_ctl[SHARED_BIT] && st_reg.zf_ctl[FPOL_BIT]
       && st_reg.pin_ctl[RPIN_LSB+1:RPIN_LSB] == RPIN_BOTH)
        |=> RIGHT_FLAG_PIN == ($past(zero_l) && $past(zero_r));
  endproperty
  a_right_both: assert property (p_right_both)
    else $error("right pin not showing both-zero");
endmodule

/* File: rtl/dac_ctl_pkg.sv */
// Constants, field layouts and carrier types for the DAC control block.
// Assumes one 10 MHz clock that is also the DAC master clock.
// What this block does
// - The DAC takes its samples from the source named by a three-bit code: 0 ADC, 1 receiver, 2 playback, 3 auxiliary, 4 rate converter.
// - The transmitter takes its samples from the source named by its own three-bit code with the same five meanings.
// - While the hard reset bit is 1 the DAC sits in reset and low power with outputs at ground, otherwise it runs.
// - While the digital reset bit is 1 all DAC logic except the configuration registers is held in reset; the zero flag pins are not held.
// - Channels are routed by a two-bit code (normal, both right, both left, swapped), inverted by a polarity code and silenced when their mute bit is 0.
// - The master clock is divided by 1, 1.5, 2 or 3 and the interpolator ratio 8x, 4x or 2x sets 256, 128 or 64 clocks per sample, code 3 reserved.
// - Mute or zero volume raises a channel's zero flag only while the silence-disable bit is 0.
// - Zero input data raises a channel's zero flag only while the null-data-disable bit is 0.
// - The zero flag pins are active low when the polarity bit is 0 and active high when it is 1.
// - The shared left pin carries the left zero flag when the pin-function bit is 0 and the interrupt when it is 1.
// - With the shared pin on interrupt duty the right pin shows right flag, left flag, either zero or both zero per a two-bit code.
package dac_ctl_pkg;
  localparam int SAMPLE_W = 24;
  localparam int NUM_FEEDS = 5;

  localparam logic [6:0] ADDR_SOURCE_SEL = 7'h63;
  localparam logic [6:0] ADDR_MAIN       = 7'h64;
  localparam logic [6:0] ADDR_CLK_FILT   = 7'h65;
  localparam logic [6:0] ADDR_ZERO_FLAG  = 7'h66;
  localparam logic [6:0] ADDR_PIN_FUNC   = 7'h67;

  localparam int HARD_BIT = 7;
  localparam int DIG_BIT = 6;
  localparam int ROUTE_LSB = 4;
  localparam int INV_LSB = 2;
  localparam int RSIL_BIT = 1;
  localparam int LSIL_BIT = 0;
  localparam int DIV_LSB = 4;
  localparam int INTERP_LSB = 2;
  localparam int SILDIS_BIT = 2;
  localparam int NULLDIS_BIT = 1;
  localparam int FPOL_BIT = 0;
  localparam int SHARED_BIT = 6;
  localparam int RPIN_LSB = 4;
  localparam int DACSEL_LSB = 3;
  localparam int TXSEL_LSB = 0;

  localparam logic [7:0] MAIN_MASK = 8'hFF;
  localparam logic [7:0] CLK_MASK  = 8'h3F;
  localparam logic [7:0] ZF_MASK   = 8'h07;
  localparam logic [7:0] PIN_MASK  = 8'h70;
  localparam logic [7:0] SEL_MASK  = 8'h3F;
  localparam logic [7:0] REG_RESET = 8'h00;

  localparam logic [2:0] SEL_ADC = 3'h0;
  localparam logic [2:0] SEL_RX = 3'h1;
  localparam logic [2:0] SEL_PLAY = 3'h2;
  localparam logic [2:0] SEL_AUX = 3'h3;
  localparam logic [2:0] SEL_RATECONV = 3'h4;

  localparam logic [1:0] ROUTE_NORMAL = 2'h0;
  localparam logic [1:0] ROUTE_BOTH_R = 2'h1;
  localparam logic [1:0] ROUTE_BOTH_L = 2'h2;
  localparam logic [1:0] ROUTE_SWAP = 2'h3;

  localparam logic [1:0] DIV_1 = 2'h0;
  localparam logic [1:0] DIV_1P5 = 2'h1;
  localparam logic [1:0] DIV_2 = 2'h2;
  localparam logic [1:0] DIV_3 = 2'h3;
  localparam logic [1:0] INTERP_8X = 2'h0;
  localparam logic [1:0] INTERP_4X = 2'h1;
  localparam logic [1:0] INTERP_2X = 2'h2;
  localparam logic [7:0] FS_TERM_8X = 8'hFF;
  localparam logic [7:0] FS_TERM_4X = 8'h7F;
  localparam logic [7:0] FS_TERM_2X = 8'h3F;

  localparam logic [1:0] RPIN_RIGHT = 2'h0;
  localparam logic [1:0] RPIN_LEFT = 2'h1;
  localparam logic [1:0] RPIN_EITHER = 2'h2;
  localparam logic [1:0] RPIN_BOTH = 2'h3;

  localparam logic [4:0] HDR_BITS = 5'h08;
  localparam logic [4:0] FRAME_BITS = 5'h10;

  typedef struct packed {
    logic [SAMPLE_W-1:0] left;
    logic [SAMPLE_W-1:0] right;
  } stereo_s;

  typedef struct packed {
    logic       stb;
    logic [6:0] addr;
    logic [7:0] data;
  } reg_wr_s;
endpackage

/* File: rtl/dac_spi_port.sv */
// Serial control port: 7 address bits, read flag, 8 data bits, MSB first.
// Assumes CS_N, SCK and SDI are already synchronous to the system clock.
`timescale 1ns/1ns
module dac_spi_port
  import dac_ctl_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Serial pins
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic       sdi,
  output logic            sdo,
  // Register side
  input  wire logic [7:0] rd_data,
  output logic [6:0]      rd_addr,
  output reg_wr_s         wr
);
  typedef struct packed {
    logic       sck_d;
    logic [4:0] cnt;
    logic [15:0] sh;
    logic [6:0] tx;
    logic       sdo;
    reg_wr_s    wr;
  } spi_s;

  spi_s st_reg;
  spi_s st_next;

  always_comb begin
    st_next = st_reg;
    st_next.wr.stb = 1'b0;
    st_next.sck_d = sck;
    if (cs_n) begin
      st_next.cnt = 5'h00;
      st_next.sdo = 1'b0;
    end else if (sck && !st_reg.sck_d) begin
      st_next.sh = {st_reg.sh[14:0], sdi};
      if (st_reg.cnt < FRAME_BITS) begin
        st_next.cnt = st_reg.cnt + 5'h01;
      end
      if (st_reg.cnt == FRAME_BITS - 5'h01 && !st_reg.sh[7]) begin
        st_next.wr = '{1'b1, st_reg.sh[14:8], {st_reg.sh[6:0], sdi}};
      end
    end else if (!sck && st_reg.sck_d) begin
      // Read data leaves on falling edges so the host samples it rising
      if (st_reg.cnt == HDR_BITS && st_reg.sh[0]) begin
        st_next.sdo = rd_data[7];
        st_next.tx = rd_data[6:0];
      end else if (st_reg.cnt > HDR_BITS) begin
        st_next.sdo = st_reg.tx[6];
        st_next.tx = {st_reg.tx[5:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sdo = st_reg.sdo;
  assign wr = st_reg.wr;
  assign rd_addr = st_reg.sh[7:1];

  property p_frame_idle;
    @(posedge clk) disable iff (!rst_n)
      cs_n |=> (st_reg.cnt == 5'h00 && !wr.stb);
  endproperty
  a_frame_idle: assert property (p_frame_idle)
    else $error("serial port not idle while deselected");
endmodule

/* File: rtl/dac_rate_gen.sv */
// Master clock divider and sample-rate tick for the DAC path.
// Assumes the system clock stands in for the DAC master clock.
`timescale 1ns/1ns
module dac_rate_gen
  import dac_ctl_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clr,
  // Settings
  input  wire logic [1:0] div_sel,
  input  wire logic [1:0] interp_sel,
  // Enables
  output logic            mclk_en,
  output logic            fs_tick
);
  typedef struct packed {
    logic [1:0] ph;
    logic [7:0] fs_cnt;
    logic       en;
    logic       tick;
  } rate_s;

  rate_s st_reg;
  rate_s st_next;
  logic  last;
  logic [7:0] term;

  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    last = (div_sel == DIV_2) ? (st_reg.ph == 2'h1) : (st_reg.ph == 2'h2);
    case (div_sel)
      DIV_1:   st_next.en = 1'b1;
      DIV_1P5: st_next.en = (st_reg.ph != 2'h2);
      DIV_2:   st_next.en = (st_reg.ph == 2'h0);
      // Skip after a live enable so switching in never doubles up
      DIV_3:   st_next.en = (st_reg.ph == 2'h0) && !st_reg.en;
      default: st_next.en = 1'b1;
    endcase
    st_next.ph = (last || div_sel == DIV_1) ? 2'h0 : st_reg.ph + 2'h1;
    case (interp_sel)
      INTERP_8X: term = FS_TERM_8X;
      INTERP_4X: term = FS_TERM_4X;
      INTERP_2X: term = FS_TERM_2X;
      default:   term = FS_TERM_2X;
    endcase
    if (st_reg.en) begin
      if (st_reg.fs_cnt >= term) begin
        st_next.fs_cnt = 8'h00;
        st_next.tick = 1'b1;
      end else begin
        st_next.fs_cnt = st_reg.fs_cnt + 8'h01;
      end
    end
    if (clr) begin
      st_next = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign mclk_en = st_reg.en;
  assign fs_tick = st_reg.tick;

  property p_div3_gap;
    @(posedge clk) disable iff (!rst_n)
      (mclk_en && div_sel == DIV_3 && !clr) ##1 (div_sel == DIV_3 && !clr)
        |-> !mclk_en;
  endproperty
  a_div3_gap: assert property (p_div3_gap)
    else $error("divide by three gave back-to-back enables");
endmodule

/* File: tb/spi_host_model.sv */
// Host side of the serial control port: 16-bit frames, MSB first.
// Assumes the bench calls xfer from a falling edge of REF_CLK.
`timescale 1ns/1ns
module spi_host_model (
  input  wire logic clk,
  input  wire logic sdo,
  output logic      cs_n,
  output logic      sck,
  output logic      sdi
);
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    sdi  = 1'b0;
  end

  // Two REF_CLK per SCK phase; the port's edge detect can follow as few as one
  task automatic xfer(input logic [15:0] frm, output logic [7:0] q);
    q = 8'h00;
    @(negedge clk);
    cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sck = 1'b0;
      sdi = frm[i];
      repeat (2) @(negedge clk);
      sck = 1'b1;
      if (i < 8) begin
        q = {q[6:0], sdo};
      end
      repeat (2) @(negedge clk);
    end
    sck = 1'b0;
    @(negedge clk);
    cs_n = 1'b1;
    // Released line must not keep showing the last bit
    sdi  = ~sdi;
    repeat (3) @(negedge clk);
  endtask
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the DAC control and routing block.
// Assumes the serial host model and a 10 MHz REF_CLK.
`timescale 1ns/1ns
module tb_top
  import dac_ctl_pkg::*;
;
  logic                    ref_clk;
  logic                    resetn;
  logic                    cs_n, sck, sdi, sdo;
  stereo_s [NUM_FEEDS-1:0] feed;
  logic                    vz_l, vz_r, irq;
  stereo_s                 dac_data, tx_data;
  logic                    strobe, pdn, mclk_en, pin_l, pin_r;
  int                      n_fail = 0;
  int                      checked = 0;
  int                      n, ns, ne;

  localparam logic [6:0] ADRS [5] = '{ADDR_SOURCE_SEL, ADDR_MAIN,
    ADDR_CLK_FILT, ADDR_ZERO_FLAG, ADDR_PIN_FUNC};
  localparam logic [7:0] MSKS [5] = '{SEL_MASK, MAIN_MASK, CLK_MASK,
    ZF_MASK, PIN_MASK};
  localparam int EN60 [4] = '{60, 40, 30, 20};
  localparam int SPAN [4] = '{256, 128, 64, 64};

  `define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

  dac_control_and_routing i_dut (
    .REF_CLK(ref_clk), .RESETN(resetn), .CS_N(cs_n), .SCK(sck),
    .SDI(sdi), .SDO(sdo), .SOURCE_DATA(feed), .VOL_ZERO_L(vz_l),
    .VOL_ZERO_R(vz_r), .IRQ_IN(irq), .DAC_DATA(dac_data),
    .DAC_STROBE(strobe), .DAC_POWER_DOWN(pdn), .DAC_MCLK_EN(mclk_en),
    .TX_DATA(tx_data), .LEFT_FLAG_OR_IRQ_PIN(pin_l),
    .RIGHT_FLAG_PIN(pin_r)
  );

  spi_host_model i_host (
    .clk(ref_clk), .sdo(sdo), .cs_n(cs_n), .sck(sck), .sdi(sdi)
  );

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    i_host.xfer({a, 1'b0, d}, q);
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] q;
    i_host.xfer({a, 1'b1, 8'h00}, q);
    `CHK(q, e)
  endtask

  // Cycles up to the next strobe, bounded so a dead tick cannot hang
  task automatic next_strobe(output int c);
    c = 0;
    do begin
      @(negedge ref_clk);
      c++;
    end while (strobe !== 1'b1 && c < 600);
    if (strobe !== 1'b1) n_fail++;
  endtask

  task automatic count(input int cyc, output int s, output int e);
    s = 0;
    e = 0;
    repeat (cyc) begin
      @(negedge ref_clk);
      if (strobe === 1'b1) s++;
      if (mclk_en === 1'b1) e++;
    end
  endtask

  function automatic stereo_s exp_dac(stereo_s s, logic [7:0] m);
    stereo_s o;
    o.left  = m[4] ? s.right : s.left;
    o.right = m[5] ? s.left : s.right;
    if (m[2]) o.left = -o.left;
    if (m[3]) o.right = -o.right;
    if (!m[0]) o.left = '0;
    if (!m[1]) o.right = '0;
    return o;
  endfunction

  task automatic t_regs();
    `CHK(pin_l, 1'b0)
    `CHK(pin_r, 1'b0)
    for (int i = 0; i < 5; i++) begin
      rd_chk(ADRS[i], REG_RESET);
      wr(ADRS[i], 8'hFF);
      rd_chk(ADRS[i], MSKS[i]);
    end
    wr(7'h10, 8'hFF);
    rd_chk(7'h10, 8'h00);
  endtask

  task automatic t_source();
    wr(ADDR_MAIN, 8'h03);
    wr(ADDR_CLK_FILT, 8'h08);
    for (int c = 0; c < 5; c++) begin
      wr(ADDR_SOURCE_SEL, 8'(c * 8 + 4 - c));
      next_strobe(n);
      next_strobe(n);
      `CHK(dac_data, feed[c])
      `CHK(tx_data, feed[4 - c])
    end
  endtask

  task automatic t_route();
    wr(ADDR_SOURCE_SEL, 8'h12);
    for (int m = 0; m < 64; m++) begin
      wr(ADDR_MAIN, 8'(m));
      next_strobe(n);
      next_strobe(n);
      `CHK(dac_data, exp_dac(feed[2], 8'(m)))
    end
  endtask

  task automatic t_reset();
    wr(ADDR_MAIN, 8'h83);
    `CHK(pdn, 1'b1)
    count(300, ns, ne);
    `CHK(ns, 0)
    `CHK(dac_data, 48'h0)
    `CHK(tx_data, 48'h0)
    rd_chk(ADDR_CLK_FILT, 8'h08);
    wr(ADDR_MAIN, 8'h43);
    `CHK(pdn, 1'b0)
    count(300, ns, ne);
    `CHK(ns, 0)
    rd_chk(ADDR_MAIN, 8'h43);
    wr(ADDR_MAIN, 8'h03);
    next_strobe(n);
    `CHK(dac_data, exp_dac(feed[2], 8'h03))
  endtask

  task automatic t_clock();
    for (int d = 0; d < 4; d++) begin
      wr(ADDR_CLK_FILT, 8'(d * 16 + 8));
      count(60, ns, ne);
      `CHK(ne, EN60[d])
    end
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CLK_FILT, 8'(i * 4));
      next_strobe(n);
      next_strobe(n);
      `CHK(n, SPAN[i])
    end
  endtask

  task automatic flag_case(input logic [7:0] m, z, p,
                           input logic dz, input logic [1:0] vz,
                           input logic iq, el, er);
    feed[0] = dz ? 48'h0 : 48'h123456_654321;
    {vz_l, vz_r} = vz;
    irq = iq;
    wr(ADDR_MAIN, m);
    wr(ADDR_ZERO_FLAG, z);
    wr(ADDR_PIN_FUNC, p);
    repeat (140) @(negedge ref_clk);
    `CHK(pin_l, el)
    `CHK(pin_r, er)
  endtask

  task automatic t_flags();
    wr(ADDR_SOURCE_SEL, 8'h00);
    wr(ADDR_CLK_FILT, 8'h08);
    flag_case(8'h00, 8'h00, 8'h00, 0, 2'b00, 0, 0, 0);
    flag_case(8'h00, 8'h04, 8'h00, 0, 2'b00, 0, 1, 1);
    flag_case(8'h03, 8'h00, 8'h00, 0, 2'b01, 0, 1, 0);
    flag_case(8'h03, 8'h00, 8'h00, 0, 2'b10, 0, 0, 1);
    flag_case(8'h03, 8'h00, 8'h00, 1, 2'b00, 0, 0, 0);
    flag_case(8'h03, 8'h02, 8'h00, 1, 2'b00, 0, 1, 1);
    flag_case(8'h00, 8'h01, 8'h00, 0, 2'b00, 0, 1, 1);
    flag_case(8'h03, 8'h01, 8'h00, 0, 2'b00, 0, 0, 0);
    flag_case(8'h02, 8'h01, 8'h10, 0, 2'b00, 0, 1, 0);
    flag_case(8'h02, 8'h01, 8'h40, 0, 2'b00, 1, 1, 0);
    flag_case(8'h02, 8'h01, 8'h50, 0, 2'b00, 0, 0, 1);
    flag_case(8'h02, 8'h01, 8'h60, 0, 2'b00, 1, 1, 1);
    flag_case(8'h02, 8'h01, 8'h70, 0, 2'b00, 0, 0, 0);
    flag_case(8'h00, 8'h01, 8'h70, 0, 2'b00, 1, 1, 1);
  endtask

  task automatic report_and_stop();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge ref_clk);
    n_fail++;
    report_and_stop();
  end

  initial begin
    resetn = 1'b0;
    vz_l   = 1'b0;
    vz_r   = 1'b0;
    irq    = 1'b0;
    for (int i = 0; i < NUM_FEEDS; i++) begin
      feed[i] = {24'(i * 24'h111111 + 24'h010203),
                24'(i * 24'h0A0B0C + 24'h400001)};
    end
    repeat (20) @(posedge ref_clk);
    @(negedge ref_clk);
    resetn = 1'b1;
    @(negedge ref_clk);
    t_regs();
    t_source();
    t_route();
    t_reset();
    t_clock();
    t_flags();
    report_and_stop();
  end
endmodule
